// File: sdci_asserts.sv
// sdci_asserts: timing checks on the pins between controller and device.
// assumes it stands beside the link interface, on the one core clock.
`timescale 1ns/1ns
`default_nettype none
module sdci_asserts
  import sdci_pkg::*;
(
  input wire logic                   CORE_CLK,   // core clock
  input wire logic                   RESET,      // sync reset, high
  input wire logic                   cs_n,       // chip select, low
  input wire logic                   ras_n,      // row strobe
  input wire logic                   cas_n,      // column strobe
  input wire logic                   we_n,       // write enable
  input wire logic                   cke,        // clock enable
  input wire logic [1:0]             bank_sel,   // bank select
  input wire logic [sdci_pkg::ADDR_W-1:0] addr,  // address bus
  input wire logic [sdci_pkg::MASK_W-1:0] dqm,   // byte mask
  input wire logic                   dq_host_oe, // host drives dq
  input wire logic [sdci_pkg::MASK_W-1:0] dq_dev_oe // device lane drive
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic [2:0] code;
  logic       sel;
  logic       was_self;
  logic [3:0] open_bank;
  assign code = {ras_n, cas_n, we_n};
  assign sel  = !cs_n && (code != SDCI_CMD_NOP);
  // -------------------------------------------------------------------
  // self refresh tracking
  // -------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET)
      was_self <= 1'b0;
    else if (sel && code == SDCI_CMD_REFR && !cke)
      was_self <= 1'b1;
    else if (cke)
      was_self <= 1'b0;
  end
  // rows opened on the pins and not yet closed
  always_ff @(posedge CORE_CLK) begin
    if (RESET)
      open_bank <= 4'h0;
    else if (sel && code == SDCI_CMD_ACT)
      open_bank[bank_sel] <= 1'b1;
    else if (sel && code == SDCI_CMD_PRE && addr[AP_BIT])
      open_bank <= 4'h0;
    else if (sel && (code == SDCI_CMD_PRE
             || addr[AP_BIT] && (code == SDCI_CMD_RD || code == SDCI_CMD_WR)))
      open_bank[bank_sel] <= 1'b0;
  end
  a_load_gap: assert property (sel && code == SDCI_CMD_LOAD |=> !sel)
    else $error("command right after mode load");
  a_refresh_gap: assert property (sel && code == SDCI_CMD_REFR && cke |=> !sel)
    else $error("command right after auto refresh");
  a_preall_gap: assert property (sel && code == SDCI_CMD_PRE && addr[AP_BIT] |=> !sel)
    else $error("command right after precharge all");
  a_cke_high: assert property (sel && code != SDCI_CMD_REFR |-> cke)
    else $error("command with clock enable low");
  a_self_hold: assert property (sel && code == SDCI_CMD_REFR && !cke |=> !cke)
    else $error("self refresh left at once");
  a_exit_nops: assert property (was_self && cke |-> !sel [*2])
    else $error("command during self refresh exit");
  a_self_quiet: assert property (was_self && !cke |-> dq_dev_oe == 4'h0)
    else $error("device drives dq in self refresh");
  a_read_mask: assert property (!(|($past(dqm, 3) & dq_dev_oe)))
    else $error("masked read lane driven");
  a_read_data: assert property (sel && code == SDCI_CMD_RD && open_bank[bank_sel]
    && dqm == 4'h0 ##1 dqm == 4'h0 ##1 dqm == 4'h0 |-> ##[0:2] (|dq_dev_oe))
    else $error("read burst never drove dq");
  a_no_fight: assert property (!(dq_host_oe && |dq_dev_oe))
    else $error("both ends drive dq");
endmodule : sdci_asserts
`default_nettype wire

// File: sdci_device.sv
// sdci_device: dram command decoder, bank tracker, burst engine and array.
// assumes pins are driven on the same core clock by the controller end.
`timescale 1ns/1ns
`default_nettype none
module sdci_device
  import sdci_pkg::*;
#(
  parameter bit  AUTOMOTIVE = 1'b0,  // no self refresh when set
  parameter int  MEM_COLS   = 16     // stored columns per bank (model depth)
) (
  input  wire logic                   CORE_CLK,     // core clock
  input  wire logic                   RESET,        // sync reset, high
  sdci_if.dev                         LINK,         // command pins
  output logic                        SELF_REFRESH, // in self refresh
  output logic [sdci_pkg::ADDR_W-1:0] MODE_WORD,    // loaded mode op-code
  output logic [sdci_pkg::ROW_W-1:0]  REFRESH_ROW,  // refresh counter
  output logic                        ILLEGAL       // illegal command pulse
);
  import sdci_pkg::*;
  localparam int MI_W = $clog2(MEM_COLS);

  typedef struct packed {
    sdci_bank_type [BANKS-1:0]             bank;
    logic [BANKS-1:0][ROW_W-1:0]           row;
    logic [BANKS-1:0][CNT_W-1:0]           bcnt;
    logic [CNT_W-1:0]                      busy;
    logic [ADDR_W-1:0]                     mode;
    logic [ROW_W-1:0]                      rfc;
    logic                                  self;
    logic                                  burst;
    logic                                  bwr;
    logic                                  bap;
    logic [1:0]                            bbank;
    logic [COL_W-1:0]                      bcol;
    logic [CNT_W-1:0]                      blen;
    logic [READ_LATENCY_CYC-1:0]           rd_v;
    logic [READ_LATENCY_CYC-1:0][MASK_W-1:0] rd_m;
    logic [READ_LATENCY_CYC-1:0][DATA_W-1:0] rd_d;
    logic [DATA_W-1:0]                     dout;
    logic [MASK_W-1:0]                     doe;
    logic                                  illegal;
  } sdci_dev_type;

  sdci_dev_type r;
  sdci_dev_type next_r;
  logic [DATA_W-1:0] mem [BANKS][MEM_COLS];
  sdci_cmd_type      cmd;
  logic              exec;
  logic              all_idle;
  logic [MI_W-1:0]   widx;
  logic [DATA_W-1:0] rword;
  logic              wr_now;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  assign cmd  = sdci_cmd_type'({LINK.ras_n, LINK.cas_n, LINK.we_n});
  assign exec = !LINK.cs_n && !r.self && (r.busy == '0) && cmd != SDCI_CMD_NOP;
  assign widx = r.bcol[MI_W-1:0];
  assign rword = mem[r.bbank][widx];
  assign wr_now = r.burst && r.bwr && LINK.cke;

  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < BANKS; b++)
      if (r.bank[b] != SDCI_BANK_IDLE)
        all_idle = 1'b0;
  end

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.illegal = 1'b0;
    if (r.busy != '0)
      next_r.busy = r.busy - 1'b1;
    // bank precharge timers
    for (int b = 0; b < BANKS; b++) begin
      if (r.bank[b] == SDCI_BANK_PRECH) begin
        if (r.bcnt[b] <= 1)
          next_r.bank[b] = SDCI_BANK_IDLE;
        else
          next_r.bcnt[b] = r.bcnt[b] - 1'b1;
      end
    end
    // read pipeline shift: mask sampled now appears on dq_dev_oe three clocks later
    next_r.rd_v = {r.rd_v[READ_LATENCY_CYC-2:0], 1'b0};
    next_r.rd_m = {r.rd_m[READ_LATENCY_CYC-2:0], LINK.dqm};
    next_r.rd_d = {r.rd_d[READ_LATENCY_CYC-2:0], rword};
    next_r.dout = r.rd_d[READ_LATENCY_CYC-1];
    next_r.doe  = r.rd_v[READ_LATENCY_CYC-1] ? ~r.rd_m[READ_LATENCY_CYC-1] : '0;
    // burst advance
    if (r.burst && LINK.cke) begin
      if (!r.bwr)
        next_r.rd_v[0] = 1'b1;
      next_r.bcol = r.bcol + 1'b1;
      if (r.blen <= 1) begin
        next_r.burst = 1'b0;
        if (r.bap) begin
          next_r.bank[r.bbank] = SDCI_BANK_PRECH;
          next_r.bcnt[r.bbank] = CNT_W'(PRECHARGE_PERIOD_CYC);
        end
      end else
        next_r.blen = r.blen - 1'b1;
    end
    // self refresh: only cke matters
    if (r.self) begin
      if (LINK.cke) begin
        next_r.self = 1'b0;
        next_r.busy = CNT_W'(SELF_REFRESH_EXIT_CYC);
      end
    end else if (exec && (LINK.cke || cmd == SDCI_CMD_REFR)) begin
      case (cmd)
        SDCI_CMD_LOAD: begin
          if (all_idle) begin
            next_r.mode = LINK.addr;
            next_r.busy = CNT_W'(MODE_LOAD_DELAY_CYC);
          end else
            next_r.illegal = 1'b1;
        end
        SDCI_CMD_REFR: begin
          if (!all_idle)
            next_r.illegal = 1'b1;
          else if (LINK.cke) begin
            next_r.rfc  = r.rfc + 1'b1;
            next_r.busy = CNT_W'(REFRESH_CYCLE_CYC);
          end else if (AUTOMOTIVE)
            next_r.illegal = 1'b1;
          else begin
            next_r.self = 1'b1;
            next_r.rfc  = r.rfc + 1'b1;
          end
        end
        SDCI_CMD_ACT: begin
          if (r.bank[LINK.bank_sel] == SDCI_BANK_IDLE) begin
            next_r.bank[LINK.bank_sel] = SDCI_BANK_ACTIVE;
            next_r.row[LINK.bank_sel]  = LINK.addr[ROW_W-1:0];
          end else
            next_r.illegal = 1'b1;
        end
        SDCI_CMD_RD, SDCI_CMD_WR: begin
          if (r.bank[LINK.bank_sel] == SDCI_BANK_ACTIVE) begin
            next_r.burst = 1'b1;
            next_r.bwr   = (cmd == SDCI_CMD_WR);
            next_r.bap   = LINK.addr[AP_BIT];
            next_r.bbank = LINK.bank_sel;
            next_r.bcol  = LINK.addr[COL_W-1:0];
            next_r.blen  = CNT_W'(BURST_LEN);
          end else
            next_r.illegal = 1'b1;
        end
        SDCI_CMD_TERM: begin
          next_r.burst = 1'b0;
          if (r.burst && r.bap) begin
            next_r.bank[r.bbank] = SDCI_BANK_PRECH;
            next_r.bcnt[r.bbank] = CNT_W'(PRECHARGE_PERIOD_CYC);
          end
        end
        SDCI_CMD_PRE: begin
          for (int b = 0; b < BANKS; b++)
            if (LINK.addr[AP_BIT] || LINK.bank_sel == b[1:0]) begin
              if (r.bank[b] == SDCI_BANK_ACTIVE) begin
                next_r.bank[b] = SDCI_BANK_PRECH;
                next_r.bcnt[b] = CNT_W'(PRECHARGE_PERIOD_CYC);
              end
              if (r.burst && r.bbank == b[1:0])
                next_r.burst = 1'b0;
            end
        end
        default: next_r.illegal = 1'b0;
      endcase
    end else if (exec && !LINK.cke)
      next_r.illegal = 1'b1;
  end

  // -------------------------------------------------------------------
  // registers and array
  // -------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      r      <= '0;
      r.mode <= MODE_RESET;
    end else
      r <= next_r;
  end

  // write mask applies with the data word
  always_ff @(posedge CORE_CLK) begin
    if (wr_now)
      for (int i = 0; i < MASK_W; i++)
        if (!LINK.dqm[i])
          mem[r.bbank][widx][8*i +: 8] <= LINK.dq[8*i +: 8];
  end

  assign LINK.dq_dev_o  = r.dout;
  assign LINK.dq_dev_oe = r.doe;
  assign SELF_REFRESH   = r.self;
  assign MODE_WORD      = r.mode;
  assign REFRESH_ROW    = r.rfc;
  assign ILLEGAL        = r.illegal;
endmodule : sdci_device
`default_nettype wire

// File: sdci_host.sv
// sdci_host: controller end; turns user requests into pin commands, refreshes.
// assumes device on same core clock; write data staged in a two-entry buffer.
`timescale 1ns/1ns
`default_nettype none
module sdci_host
  import sdci_pkg::*;
#(
  parameter int REFRESH_INTERVAL = REFRESH_INTERVAL_CYC  // auto refresh spacing
) (
  input  wire logic                   CORE_CLK,   // core clock
  input  wire logic                   RESET,      // sync reset, high
  sdci_if.host                        LINK,       // command pins
  input  wire logic                   REQ_VALID,  // command request
  output logic                        REQ_READY,  // request taken
  input  wire sdci_pkg::sdci_cmd_type REQ_CMD,    // command code
  input  wire logic [1:0]             REQ_BANK,   // bank select
  input  wire logic [sdci_pkg::ADDR_W-1:0] REQ_ADDR, // address bus
  input  wire logic                   REQ_SELF,   // refresh as self refresh
  input  wire logic                   WAKE,       // leave self refresh
  input  wire logic                   WD_VALID,   // write data valid
  output logic                        WD_READY,   // buffer has room
  input  wire logic [sdci_pkg::DATA_W-1:0] WD_DATA, // write data
  input  wire logic [sdci_pkg::MASK_W-1:0] WD_MASK, // write lane mask
  output logic [sdci_pkg::DATA_W-1:0] RD_DATA,    // dq sampled
  output logic                        BUSY        // waiting on a timing
);
  import sdci_pkg::*;

  typedef struct packed {
    sdci_host_type          st;
    logic [CNT_W-1:0]       wait_cnt;
    logic [15:0]            ref_cnt;
    logic                   ref_due;
    logic                   cs_n;
    sdci_cmd_type           cmd;
    logic                   cke;
    logic [1:0]             bank;
    logic [ADDR_W-1:0]      addr;
    logic [1:0]             fv;
    logic [1:0][DATA_W+MASK_W-1:0] fd;
    logic                   drive;
    logic [DATA_W+MASK_W-1:0] dout;
    logic [DATA_W-1:0]      rd;
    logic                   ref_pre;
    logic [CNT_W-1:0]       beats;
    logic                   bwr;
    logic                   wbeat;
  } sdci_host_state_type;

  sdci_host_state_type r;
  sdci_host_state_type next_r;
  logic take;
  logic pop;

  assign REQ_READY = (r.st == SDCI_H_IDLE) && !r.ref_due && !REQ_SELF
                     || (r.st == SDCI_H_IDLE) && !r.ref_due && REQ_CMD == SDCI_CMD_REFR;
  assign take      = REQ_VALID && REQ_READY;
  assign WD_READY  = !r.fv[1];
  assign pop       = r.fv[0] && r.bwr && (r.beats != '0);  // drain on write beats only

  // -------------------------------------------------------------------
  // sequencing
  // -------------------------------------------------------------------
  always_comb begin
    next_r       = r;
    next_r.cs_n  = 1'b0;
    next_r.cmd   = SDCI_CMD_NOP;
    next_r.rd    = LINK.dq;
    next_r.drive = 1'b0;
    if (r.ref_cnt != '0)
      next_r.ref_cnt = r.ref_cnt - 1'b1;
    else begin
      next_r.ref_due = 1'b1;
      next_r.ref_cnt = 16'(REFRESH_INTERVAL);
    end
    // burst beats still owed; write beats without data are masked
    if (r.beats != '0)
      next_r.beats = r.beats - 1'b1;
    next_r.wbeat = r.bwr && (r.beats != '0);
    // two-entry write buffer, drains one word per cycle onto dq
    if (pop) begin
      next_r.drive = 1'b1;
      next_r.dout  = r.fd[0];
      next_r.fd[0] = r.fd[1];
      next_r.fv    = {1'b0, r.fv[1]};
    end
    if (WD_VALID && WD_READY) begin
      if (next_r.fv[0]) begin
        next_r.fd[1] = {WD_DATA, WD_MASK};
        next_r.fv[1] = 1'b1;
      end else begin
        next_r.fd[0] = {WD_DATA, WD_MASK};
        next_r.fv[0] = 1'b1;
      end
    end
    case (r.st)
      SDCI_H_RESET: begin
        next_r.st  = SDCI_H_IDLE;
        next_r.cke = 1'b1;
      end
      SDCI_H_IDLE: begin
        if (r.ref_due && r.beats == '0 && !r.ref_pre) begin
          // close every row before the refresh
          next_r.cmd      = SDCI_CMD_PRE;
          next_r.addr     = ADDR_W'(1) << AP_BIT;
          next_r.ref_pre  = 1'b1;
          next_r.st       = SDCI_H_WAIT;
          next_r.wait_cnt = CNT_W'(PRECHARGE_PERIOD_CYC);
        end else if (r.ref_due && r.beats == '0) begin
          next_r.cmd      = SDCI_CMD_REFR;
          next_r.ref_due  = (r.ref_cnt == '0);
          next_r.ref_pre  = 1'b0;
          next_r.st       = SDCI_H_WAIT;
          next_r.wait_cnt = CNT_W'(REFRESH_CYCLE_CYC);
        end else if (take) begin
          next_r.cmd  = REQ_CMD;
          next_r.bank = REQ_BANK;
          next_r.addr = REQ_ADDR;
          if (REQ_CMD == SDCI_CMD_RD || REQ_CMD == SDCI_CMD_WR) begin
            next_r.beats = CNT_W'(BURST_LEN);
            next_r.bwr   = (REQ_CMD == SDCI_CMD_WR);
          end else if (REQ_CMD == SDCI_CMD_TERM || REQ_CMD == SDCI_CMD_PRE)
            next_r.beats = '0;
          if (REQ_CMD == SDCI_CMD_REFR && REQ_SELF) begin
            next_r.cke      = 1'b0;
            next_r.st       = SDCI_H_SELF;
            next_r.wait_cnt = CNT_W'(ROW_ACTIVE_MIN_CYC);
          end else if (REQ_CMD == SDCI_CMD_LOAD) begin
            next_r.st       = SDCI_H_WAIT;
            next_r.wait_cnt = CNT_W'(MODE_LOAD_DELAY_CYC);
          end else if (REQ_CMD == SDCI_CMD_REFR) begin
            next_r.st       = SDCI_H_WAIT;
            next_r.wait_cnt = CNT_W'(REFRESH_CYCLE_CYC);
          end else if (REQ_CMD == SDCI_CMD_PRE && REQ_ADDR[AP_BIT]) begin
            next_r.st       = SDCI_H_WAIT;
            next_r.wait_cnt = CNT_W'(PRECHARGE_PERIOD_CYC);
          end
        end
      end
      SDCI_H_WAIT: begin
        if (r.wait_cnt <= 1)
          next_r.st = SDCI_H_IDLE;
        else
          next_r.wait_cnt = r.wait_cnt - 1'b1;
      end
      SDCI_H_SELF: begin
        next_r.cke = 1'b0;
        if (r.wait_cnt > 1)
          next_r.wait_cnt = r.wait_cnt - 1'b1;
        else if (WAKE) begin
          next_r.cke      = 1'b1;
          next_r.st       = SDCI_H_EXIT;
          next_r.wait_cnt = CNT_W'(SELF_REFRESH_EXIT_CYC);
        end
      end
      SDCI_H_EXIT: begin
        if (r.wait_cnt <= 1) begin
          next_r.st      = SDCI_H_IDLE;
          next_r.ref_due = 1'b1;
        end else
          next_r.wait_cnt = r.wait_cnt - 1'b1;
      end
      default: next_r.st = SDCI_H_RESET;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      r         <= '0;
      r.st      <= SDCI_H_RESET;
      r.cs_n    <= 1'b1;
      r.cmd     <= SDCI_CMD_NOP;
      r.ref_cnt <= 16'(REFRESH_INTERVAL);
    end else
      r <= next_r;
  end

  assign LINK.cs_n       = r.cs_n;
  assign {LINK.ras_n, LINK.cas_n, LINK.we_n} = r.cmd;
  assign LINK.cke        = r.cke;
  assign LINK.bank_sel   = r.bank;
  assign LINK.addr       = r.addr;
  assign LINK.dq_host_o  = r.dout[DATA_W+MASK_W-1:MASK_W];
  assign LINK.dq_host_oe = r.drive;
  assign LINK.dqm        = r.drive ? r.dout[MASK_W-1:0] : {MASK_W{r.wbeat}};
  assign RD_DATA         = r.rd;
  assign BUSY            = (r.st != SDCI_H_IDLE);
endmodule : sdci_host
`default_nettype wire

// File: sdci_if.sv
// sdci_if: the command/data pins between the memory controller and the device.
// assumes both ends run on the same core clock; dq drive is resolved here.
`timescale 1ns/1ns
`default_nettype none
interface sdci_if;
  import sdci_pkg::*;
  logic                cs_n;
  logic                ras_n;
  logic                cas_n;
  logic                we_n;
  logic                cke;
  logic [1:0]          bank_sel;
  logic [ADDR_W-1:0]   addr;
  logic [MASK_W-1:0]   dqm;
  logic [DATA_W-1:0]   dq_host_o;
  logic                dq_host_oe;
  logic [DATA_W-1:0]   dq_dev_o;
  logic [MASK_W-1:0]   dq_dev_oe;
  logic [DATA_W-1:0]   dq;
  // -------------------------------------------------------------------
  // wire resolution per byte lane
  // -------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < MASK_W; i++) begin
      if (dq_host_oe)
        dq[8*i +: 8] = dq_host_o[8*i +: 8];
      else if (dq_dev_oe[i])
        dq[8*i +: 8] = dq_dev_o[8*i +: 8];
      else
        dq[8*i +: 8] = 8'h00;
    end
  end
  modport host (output cs_n, ras_n, cas_n, we_n, cke, bank_sel, addr, dqm,
                output dq_host_o, dq_host_oe, input dq);
  modport dev  (input cs_n, ras_n, cas_n, we_n, cke, bank_sel, addr, dqm,
                output dq_dev_o, dq_dev_oe, input dq);
endinterface : sdci_if
`default_nettype wire

// File: sdci_pkg.sv
// sdci_pkg: constants and types shared by both ends of the dram command link.
// assumes a single 10 MHz core clock shared by controller and device.
package sdci_pkg;
  // -------------------------------------------------------------------
  // widths
  // -------------------------------------------------------------------
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 32;
  localparam int MASK_W      = 4;
  localparam int ROW_W       = 11;
  localparam int COL_W       = 8;
  localparam int BANKS       = 4;
  localparam int AP_BIT      = 10;
  // -------------------------------------------------------------------
  // timing, in core clock cycles at 100 ns
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 100;
  localparam int MODE_LOAD_DELAY_CYC    = 2;
  localparam int PRECHARGE_PERIOD_NS    = 15;
  localparam int PRECHARGE_PERIOD_CYC   =
    (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYCLE_NS       = 66;
  localparam int REFRESH_CYCLE_CYC      =
    (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_ACTIVE_MIN_NS      = 42;
  localparam int ROW_ACTIVE_MIN_CYC     =
    (ROW_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELF_REFRESH_EXIT_NS   = 70;
  localparam int SELF_REFRESH_EXIT_RAW  =
    (SELF_REFRESH_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELF_REFRESH_EXIT_CYC  =
    (SELF_REFRESH_EXIT_RAW < 2) ? 2 : SELF_REFRESH_EXIT_RAW;
  localparam int REFRESH_INTERVAL_PS    = 15625000;
  localparam int REFRESH_INTERVAL_CYC   = REFRESH_INTERVAL_PS / (CLK_PERIOD_NS * 1000);
  localparam int READ_LATENCY_CYC       = 2;
  localparam int BURST_LEN              = 4;
  localparam int CNT_W                  = 8;
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
  // -------------------------------------------------------------------
  // command code {ras_n, cas_n, we_n}
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    SDCI_CMD_LOAD  = 3'b000,
    SDCI_CMD_REFR  = 3'b001,
    SDCI_CMD_PRE   = 3'b010,
    SDCI_CMD_ACT   = 3'b011,
    SDCI_CMD_WR    = 3'b100,
    SDCI_CMD_RD    = 3'b101,
    SDCI_CMD_TERM  = 3'b110,
    SDCI_CMD_NOP   = 3'b111
  } sdci_cmd_type;
  typedef enum logic [1:0] {
    SDCI_BANK_IDLE   = 2'b00,
    SDCI_BANK_ACTIVE = 2'b01,
    SDCI_BANK_PRECH  = 2'b10
  } sdci_bank_type;
  typedef enum logic [2:0] {
    SDCI_H_RESET = 3'b000,
    SDCI_H_IDLE  = 3'b001,
    SDCI_H_WAIT  = 3'b010,
    SDCI_H_SELF  = 3'b011,
    SDCI_H_EXIT  = 3'b100
  } sdci_host_type;
endpackage : sdci_pkg

// File: testbench.sv
// testbench: drives the controller's user side, device faces it over the link.
// assumes the controller runs with a 400-cycle refresh interval, longer than the 156-cycle default.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sdci_pkg::*;
  logic CORE_CLK, RESET, REQ_VALID, REQ_READY, REQ_SELF, WAKE, WD_VALID, WD_READY;
  logic BUSY, SELF_REFRESH, ILLEGAL;
  sdci_cmd_type REQ_CMD;
  logic [1:0] REQ_BANK;
  logic [11:0] REQ_ADDR, MODE_WORD, mw;
  logic [31:0] WD_DATA, RD_DATA;
  logic [3:0] WD_MASK;
  logic [10:0] REFRESH_ROW, r0;
  logic [31:0] a[4], b[4], exp_q[$];
  logic [3:0] mk[4], zero[4];
  logic [31:0] rd_exp;
  logic rd_chk;
  int n_mismatch, tests_run, n_ill;
  sdci_if link ();
  sdci_host #(.REFRESH_INTERVAL(400)) u_sdci_host (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .LINK(link.host), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ_CMD(REQ_CMD),
    .REQ_BANK(REQ_BANK), .REQ_ADDR(REQ_ADDR), .REQ_SELF(REQ_SELF), .WAKE(WAKE),
    .WD_VALID(WD_VALID), .WD_READY(WD_READY), .WD_DATA(WD_DATA), .WD_MASK(WD_MASK),
    .RD_DATA(RD_DATA), .BUSY(BUSY));
  sdci_device u_sdci_device (.CORE_CLK(CORE_CLK), .RESET(RESET), .LINK(link.dev),
    .SELF_REFRESH(SELF_REFRESH), .MODE_WORD(MODE_WORD), .REFRESH_ROW(REFRESH_ROW),
    .ILLEGAL(ILLEGAL));
  sdci_asserts u_sdci_asserts (.CORE_CLK(CORE_CLK), .RESET(RESET), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .cke(link.cke),
    .bank_sel(link.bank_sel), .addr(link.addr), .dqm(link.dqm),
    .dq_host_oe(link.dq_host_oe),
    .dq_dev_oe(link.dq_dev_oe));
  // -------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic idle(int k);
    repeat (k) @(posedge CORE_CLK);
  endtask : idle
  task automatic send(sdci_cmd_type c, logic [1:0] bk, logic [11:0] ad, logic s);
    int n;
    n = 0;
    REQ_VALID <= 1'b1;
    REQ_CMD <= c;
    REQ_BANK <= bk;
    REQ_ADDR <= ad;
    REQ_SELF <= s;
    @(posedge CORE_CLK);
    while (REQ_READY !== 1'b1 && n < 500) begin
      @(posedge CORE_CLK);
      n++;
    end
    if (n >= 500) n_mismatch++;
    REQ_VALID <= 1'b0;
    @(posedge CORE_CLK);
  endtask : send
  task automatic push(logic [31:0] d, logic [3:0] m);
    int n;
    n = 0;
    WD_VALID <= 1'b1;
    WD_DATA <= d;
    WD_MASK <= m;
    @(posedge CORE_CLK);
    while (WD_READY !== 1'b1 && n < 100) begin
      @(posedge CORE_CLK);
      n++;
    end
    if (n >= 100) n_mismatch++;
  endtask : push
  // two words fill the buffer, the rest follow the write command
  task automatic wburst(logic [31:0] d[4], logic [3:0] m[4]);
    push(d[0], m[0]);
    push(d[1], m[1]);
    @(posedge CORE_CLK);
    check("ready while full", 32'h0, 32'(WD_READY));
    fork
      send(SDCI_CMD_WR, 2'h1, 12'h004, 1'b0);
      begin
        push(d[2], m[2]);
        push(d[3], m[3]);
        WD_VALID <= 1'b0;
      end
    join
  endtask : wburst
  function automatic logic [31:0] lanes(logic [3:0] m);
    return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction : lanes
  // -------------------------------------------------------------------
  // clock, monitor, watchdog, sequence
  // -------------------------------------------------------------------
  initial begin
    CORE_CLK = 1'b0;
    forever #50 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    if (ILLEGAL === 1'b1) n_ill++;
    if (rd_chk)
      check("read data port", rd_exp, RD_DATA);
    rd_chk = 1'b0;
    if (link.dq_dev_oe !== 4'h0 && exp_q.size() > 0) begin
      rd_exp = exp_q[0];
      rd_chk = 1'b1;
      check("read data", exp_q.pop_front(), link.dq);
    end
  end
  initial begin
    idle(5000);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {RESET, REQ_VALID, REQ_SELF, WAKE, WD_VALID} = 5'h10;
    {REQ_CMD, REQ_BANK, REQ_ADDR, WD_DATA, WD_MASK} = {SDCI_CMD_NOP, 50'h0};
    void'($urandom(85));
    idle(20);
    RESET <= 1'b0;
    idle(3);
    mw = 12'($urandom());
    send(SDCI_CMD_LOAD, 2'h0, mw, 1'b0);
    check("busy after load", 32'h1, 32'(BUSY));
    idle(2);
    check("mode word", 32'(mw), 32'(MODE_WORD));
    check("busy over", 32'h0, 32'(BUSY));
    send(SDCI_CMD_ACT, 2'h1, 12'h155, 1'b0);
    for (int i = 0; i < 4; i++) begin
      a[i] = $urandom();
      b[i] = $urandom();
      mk[i] = 4'($urandom());
      zero[i] = 4'h0;
    end
    wburst(a, zero);
    idle(4);
    wburst(b, mk);
    idle(4);
    for (int i = 0; i < 4; i++)
      exp_q.push_back((a[i] & lanes(mk[i])) | (b[i] & ~lanes(mk[i])));
    send(SDCI_CMD_RD, 2'h1, 12'h404, 1'b0);
    idle(12);
    check("read beats left", 32'h0, 32'(exp_q.size()));
    send(SDCI_CMD_ACT, 2'h1, 12'h2AA, 1'b0);
    send(SDCI_CMD_RD, 2'h2, 12'h000, 1'b0);
    send(SDCI_CMD_PRE, 2'h0, 12'h400, 1'b0);
    send(SDCI_CMD_RD, 2'h1, 12'h004, 1'b0);
    idle(3);
    check("illegal count", 32'h2, 32'(n_ill));
    r0 = REFRESH_ROW;
    idle(450);
    check("refresh row moved", 32'h1, 32'(REFRESH_ROW !== r0));
    send(SDCI_CMD_REFR, 2'h0, 12'h000, 1'b1);
    idle(4);
    check("self refresh on", 32'h1, 32'(SELF_REFRESH));
    idle(40);
    WAKE <= 1'b1;
    for (int n = 0; n < 20 && SELF_REFRESH !== 1'b0; n++) idle(1);
    check("self refresh off", 32'h0, 32'(SELF_REFRESH));
    WAKE <= 1'b0;
    send(SDCI_CMD_ACT, 2'h3, 12'h011, 1'b0);
    idle(4);
    check("illegal after exit", 32'h2, 32'(n_ill));
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
